// *** bench/t2_asserts.sv ***
/*
  Port-level assertions for the timer-2 block, bound to t2_timer.
  Assumes the register map and pulse timing declared in t2_pkg.
*/
`timescale 1ns/1ps
module t2_asserts
  import t2_pkg::*;
(
  input wire logic             pclk,
  input wire logic             presetn,
  input wire logic             psel,
  input wire logic             penable,
  input wire logic             pwrite,
  input wire logic [7:0]       paddr,
  input wire logic [31:0]      pwdata,
  input wire logic [31:0]      prdata,
  input wire logic             overflow_pulse,
  input wire t2_pkg::t2_baud_t baud_sel,
  input wire logic             irq
);
  logic [1:0] mask_ff;
  logic       run_ff;
  wire        acc = psel && penable;
  wire        wr  = acc && pwrite;
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
    begin
      mask_ff <= 2'h0;
      run_ff  <= 1'b0;
    end
    else if (wr)
    begin
      if (paddr == OFS_IRQ_MASK)
        mask_ff <= pwdata[1:0];
      if (paddr == OFS_CONTROL)
        run_ff <= pwdata[BIT_RUN];
    end
  sequence ctl_wr;
    wr && paddr == OFS_CONTROL;
  endsequence
  sequence ctl_rd;
    acc && !pwrite && paddr == OFS_CONTROL;
  endsequence
  default clocking @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  a_port1_route:
    assert property (ctl_wr |=> {baud_sel.rx1_t2, baud_sel.tx1_t2}
      == $past(pwdata[5:4])) else $error("port 1 select wrong");
  a_port2_route:
    assert property (wr && paddr == OFS_POWER |=> {baud_sel.rx2_t2,
      baud_sel.tx2_t2} == $past(pwdata[1:0])) else $error("port 2 wrong");
  a_ctl_readback:
    assert property (ctl_rd |-> prdata[5:4] == {baud_sel.rx1_t2,
      baud_sel.tx1_t2}) else $error("select readback wrong");
  a_mask_quiet:
    assert property (wr && paddr == OFS_IRQ_MASK && pwdata[1:0] == 2'h0
      |=> !irq) else $error("irq while masked");
  a_ovf_irq:
    assert property (overflow_pulse && mask_ff[0] && baud_sel == 4'h0
      |-> ##[0:1] irq) else $error("overflow gave no irq");
  a_baud_quiet:
    assert property (!$past(irq, 2) && overflow_pulse && mask_ff == 2'h1
      && baud_sel != 4'h0 |=> !irq) else $error("flag set in baud mode");
  a_stop_silent:
    assert property (!run_ff [*3] |-> !overflow_pulse)
      else $error("overflow while stopped");
  a_irq_sticky:
    assert property ($fell(irq) |-> $past(wr))
      else $error("irq dropped without a write");
endmodule
bind t2_timer t2_asserts i_t2_asserts (.pclk(pclk), .presetn(presetn),
  .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
  .pwdata(pwdata), .prdata(prdata), .overflow_pulse(overflow_pulse),
  .baud_sel(baud_sel), .irq(irq));

// *** bench/t2_pins.sv ***
/*
  Far-side pin model: trigger and count inputs of timer 2.
  Assumes its tasks are called from the pclk domain; pins idle high.
*/
`timescale 1ns/1ps
module t2_pins
(
  input  wire logic pclk,
  output logic      trigger_pin,
  output logic      count_pin
);
  initial
  begin
    trigger_pin = 1'b1;
    count_pin   = 1'b1;
  end
  task automatic trig(input logic lvl);
    @(posedge pclk);
    trigger_pin <= lvl;
    repeat (6) @(posedge pclk);
  endtask
  task automatic cnt_fall();
    @(posedge pclk);
    count_pin <= 1'b0;
    repeat (4) @(posedge pclk);
    count_pin <= 1'b1;
    repeat (4) @(posedge pclk);
  endtask
endmodule

// *** bench/t2_timer_bench.sv ***
/*
  Self-checking bench for t2_timer with the pin model.
  Assumes zero-wait APB and one machine tick per 12 pclk.
*/
`timescale 1ns/1ps
module t2_timer_bench;
  import t2_pkg::*;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic        trigger_pin, count_pin, overflow_pulse, irq, perr;
  logic [7:0]  paddr, q;
  logic [31:0] pwdata, prdata;
  t2_baud_t    baud_sel;
  int          n_errors, checks;
  int          n_pulses = 0;
  t2_timer i_t2_timer (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .trigger_pin(trigger_pin), .count_pin(count_pin),
    .overflow_pulse(overflow_pulse), .baud_sel(baud_sel), .irq(irq));
  t2_pins i_t2_pins (.pclk(pclk), .trigger_pin(trigger_pin),
    .count_pin(count_pin));
  // Counts overflow pulses handed to the serial ports
  always @(posedge pclk)
    if (overflow_pulse === 1'b1)
      n_pulses++;
  initial
  begin
    pclk = 1'b0;
    forever #12.5 pclk = ~pclk;
  end
  task automatic apb(input logic w, input logic [7:0] a, d);
    @(posedge pclk);
    psel    <= 1'b1;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= {24'h0, d};
    @(posedge pclk);
    penable <= 1'b1;
    do
      @(posedge pclk);
    while (pready !== 1'b1);
    q = prdata[7:0];
    perr = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic chk(input string n, input logic [7:0] e, g);
    checks++;
    if (g !== e)
    begin
      n_errors++;
      $display("unexpected %s exp %h got %h", n, e, g);
    end
  endtask
  task automatic wr(input logic [7:0] a, d);
    apb(1'b1, a, d);
  endtask
  task automatic rd(input logic [7:0] a, e);
    apb(1'b0, a, 8'h00);
    chk($sformatf("reg_%h", a), e, q);
  endtask
  task automatic fall();
    i_t2_pins.trig(1'b0);
    i_t2_pins.trig(1'b1);
  endtask
  task automatic s_reset();
    rd(OFS_CONTROL, RST_CONTROL);
    rd(OFS_CAPLOW, RST_BYTE);
    apb(1'b0, 8'h40, 8'h00);
    chk("pslverr", 8'h01, {7'h0, perr});
  endtask
  task automatic s_overflow();
    int p0;
    wr(OFS_IRQ_MASK, 8'h01);
    wr(OFS_CAPLOW, 8'h20);
    wr(OFS_CAPHIGH, 8'hAB);
    wr(OFS_CNTLOW, 8'hFE);
    wr(OFS_CNTHIGH, 8'hFF);
    p0 = n_pulses;
    wr(OFS_CONTROL, 8'h04);
    repeat (40) @(posedge pclk);
    chk("irq", 8'h01, {7'h0, irq});
    chk("overflow_pulse", 8'h01, 8'(n_pulses - p0));
    rd(OFS_IRQ_STAT, 8'h01);
    wr(OFS_CONTROL, 8'h80);
    rd(OFS_CONTROL, 8'h80);
    rd(OFS_CNTHIGH, 8'hAB);
    wr(OFS_CONTROL, 8'h00);
    rd(OFS_CONTROL, 8'h00);
    wr(OFS_IRQ_STAT, 8'h03);
    @(posedge pclk);
    chk("irq", 8'h00, {7'h0, irq});
  endtask
  task automatic s_count();
    wr(OFS_CNTLOW, 8'h10);
    wr(OFS_CNTHIGH, 8'h00);
    wr(OFS_CONTROL, 8'h06);
    repeat (3) i_t2_pins.cnt_fall();
    rd(OFS_CNTLOW, 8'h13);
    wr(OFS_MODE, 8'h01);
    i_t2_pins.trig(1'b0);
    repeat (2) i_t2_pins.cnt_fall();
    rd(OFS_CNTLOW, 8'h11);
    i_t2_pins.trig(1'b1);
    i_t2_pins.cnt_fall();
    rd(OFS_CNTLOW, 8'h12);
    wr(OFS_CONTROL, 8'h02);
    i_t2_pins.cnt_fall();
    rd(OFS_CNTLOW, 8'h12);
    wr(OFS_MODE, 8'h00);
  endtask
  task automatic s_capture();
    wr(OFS_CONTROL, 8'h07);
    fall();
    rd(OFS_CONTROL, 8'h07);
    rd(OFS_CAPHIGH, 8'hAB);
    wr(OFS_CONTROL, 8'h0F);
    fall();
    rd(OFS_CONTROL, 8'h4F);
    rd(OFS_CAPLOW, 8'h12);
    rd(OFS_CAPHIGH, 8'h00);
    wr(OFS_IRQ_MASK, 8'h02);
    @(posedge pclk);
    chk("irq", 8'h01, {7'h0, irq});
    wr(OFS_CNTLOW, 8'h55);
    wr(OFS_CONTROL, 8'h0E);
    fall();
    rd(OFS_CNTLOW, 8'h12);
  endtask
  task automatic s_baud();
    int p0;
    wr(OFS_IRQ_STAT, 8'h03);
    rd(OFS_CONTROL, 8'h0E);
    wr(OFS_IRQ_MASK, 8'h01);
    wr(OFS_POWER, 8'h03);
    wr(OFS_CONTROL, 8'h10);
    @(posedge pclk);
    chk("baud_sel", 8'h07, {4'h0, baud_sel});
    wr(OFS_CONTROL, 8'h39);
    @(posedge pclk);
    chk("baud_sel", 8'h0F, {4'h0, baud_sel});
    wr(OFS_CNTLOW, 8'h5A);
    fall();
    rd(OFS_CONTROL, 8'h79);
    rd(OFS_CAPLOW, 8'h12);
    rd(OFS_CNTLOW, 8'h5A);
    wr(OFS_CAPHIGH, 8'h66);
    wr(OFS_CNTLOW, 8'hFF);
    wr(OFS_CNTHIGH, 8'hFF);
    p0 = n_pulses;
    wr(OFS_CONTROL, 8'h7D);
    repeat (30) @(posedge pclk);
    chk("overflow_pulse", 8'h01, 8'(n_pulses - p0));
    rd(OFS_CNTHIGH, 8'h66);
    rd(OFS_CONTROL, 8'h7D);
    chk("irq", 8'h00, {7'h0, irq});
    wr(OFS_CONTROL, 8'h00);
    wr(OFS_IRQ_MASK, 8'h00);
  endtask
  task automatic report_and_stop();
    if (n_errors == 0 && checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  initial
  begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    n_errors = 0;
    checks = 0;
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    s_reset();
    s_overflow();
    s_count();
    s_capture();
    s_baud();
    report_and_stop();
  end
  initial
  begin
    repeat (20000) @(posedge pclk);
    n_errors++;
    report_and_stop();
  end
endmodule

// *** hdl/t2_pkg.sv ***
/*
  Package for the timer-2 block: register offsets, field positions,
  reset values, the machine-tick divider and the carrier structs.
  Assumes a 32-bit APB bus and a single pclk domain.
*/
package t2_pkg;
  localparam logic [7:0] OFS_CONTROL  = 8'h00;
  localparam logic [7:0] OFS_CAPLOW   = 8'h04;
  localparam logic [7:0] OFS_CAPHIGH  = 8'h08;
  localparam logic [7:0] OFS_CNTLOW   = 8'h0C;
  localparam logic [7:0] OFS_CNTHIGH  = 8'h10;
  localparam logic [7:0] OFS_MODE     = 8'h14;
  localparam logic [7:0] OFS_POWER    = 8'h18;
  localparam logic [7:0] OFS_IRQ_STAT = 8'h1C;
  localparam logic [7:0] OFS_IRQ_MASK = 8'h20;

  localparam int BIT_OVF    = 7;
  localparam int BIT_EXF    = 6;
  localparam int BIT_RXSEL  = 5;
  localparam int BIT_TXSEL  = 4;
  localparam int BIT_EXEN   = 3;
  localparam int BIT_RUN    = 2;
  localparam int BIT_SRC    = 1;
  localparam int BIT_CAPSEL = 0;
  localparam int BIT_DOWN_COUNT_ENABLE   = 0;
  localparam int BIT_RX2    = 1;
  localparam int BIT_TX2    = 0;

  localparam logic [7:0]  RST_CONTROL = 8'h00;
  localparam logic [7:0]  RST_BYTE    = 8'h00;
  localparam logic [1:0]  RST_IRQ     = 2'h0;
  localparam logic [3:0]  TICK_DIV    = 4'hC;

  typedef struct packed {
    logic       ovf;
    logic       exf;
    logic       rx_sel;
    logic       tx_sel;
    logic       exen;
    logic       run;
    logic       src;
    logic       capsel;
  } t2_ctrl_t;

  typedef struct packed {
    logic       rx1_t2;
    logic       tx1_t2;
    logic       rx2_t2;
    logic       tx2_t2;
  } t2_baud_t;
endpackage

// *** hdl/t2_sync.sv ***
/*
  Two-flop synchroniser with a falling-edge detector behind it.
  Assumes an asynchronous pin input and pclk domain.
*/
`timescale 1ns/1ps
module t2_sync
(
  input  wire logic pclk,
  input  wire logic presetn,
  input  wire logic pin_in,
  output logic      level,
  output logic      fall
);
  import t2_pkg::*;
  logic             meta_ff;
  logic             sync_ff;
  logic             last_ff;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      meta_ff <= 1'b1;
      sync_ff <= 1'b1;
      last_ff <= 1'b1;
    end
    else
    begin
      meta_ff <= pin_in;
      sync_ff <= meta_ff;
      last_ff <= sync_ff;
    end
  end

  assign level = sync_ff;
  assign fall  = last_ff & ~sync_ff;
endmodule

// *** hdl/t2_tick.sv ***
/*
  Machine-clock tick generator: one pulse every DIV pclk cycles.
  Assumes the core machine cycle is a fixed division of pclk.
*/
`timescale 1ns/1ps
module t2_tick
#(
  parameter logic [3:0] DIV = t2_pkg::TICK_DIV
)
(
  input  wire logic pclk,
  input  wire logic presetn,
  output logic      tick
);
  import t2_pkg::*;
  logic [3:0]       cnt_ff;
  wire              wrap = (cnt_ff == DIV - 4'h1);

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      cnt_ff <= 4'h0;
    else
      cnt_ff <= wrap ? 4'h0 : cnt_ff + 4'h1;
  end

  assign tick = wrap;
endmodule

// *** hdl/t2_timer.sv ***
/*
  Timer 2: 16-bit capture, auto-reload and baud-rate generator with
  APB register access and a level interrupt.
  Assumes a zero-wait APB master on pclk and asynchronous trigger and
  count pins; UARTs consume the overflow pulse and the clock selects.
*/
`timescale 1ns/1ps
module t2_timer
(
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        trigger_pin,
  input  wire logic        count_pin,
  output logic             overflow_pulse,
  output t2_pkg::t2_baud_t baud_sel,
  output logic             irq
);
  import t2_pkg::*;

  t2_ctrl_t     ctl_ff;
  logic [7:0]   cap_lo_ff;
  logic [7:0]   cap_hi_ff;
  logic [15:0]  cnt_ff;
  logic         down_count_enable_ff;
  logic [1:0]   pwr_ff;
  logic [1:0]   imask_ff;
  logic         ovf_pulse_ff;

  logic         trig_lvl;
  logic         trig_fall;
  logic         cnt_fall;
  logic         mtick;

  t2_sync u_trig
  (
    .pclk    (pclk),
    .presetn (presetn),
    .pin_in  (trigger_pin),
    .level   (trig_lvl),
    .fall    (trig_fall)
  );

  t2_sync u_cnt
  (
    .pclk    (pclk),
    .presetn (presetn),
    .pin_in  (count_pin),
    .level   (),
    .fall    (cnt_fall)
  );

  t2_tick u_tick
  (
    .pclk    (pclk),
    .presetn (presetn),
    .tick    (mtick)
  );

  function automatic logic hit(input logic [7:0] a, input logic [7:0] o);
    hit = (a == o);
  endfunction

  // APB decode
  wire          wr_en    = psel & penable & pwrite;
  wire          wr_ctl   = wr_en & hit(paddr, OFS_CONTROL);
  wire          wr_caplo = wr_en & hit(paddr, OFS_CAPLOW);
  wire          wr_caphi = wr_en & hit(paddr, OFS_CAPHIGH);
  wire          wr_cntlo = wr_en & hit(paddr, OFS_CNTLOW);
  wire          wr_cnthi = wr_en & hit(paddr, OFS_CNTHIGH);
  wire          wr_mode  = wr_en & hit(paddr, OFS_MODE);
  wire          wr_pwr   = wr_en & hit(paddr, OFS_POWER);
  wire          wr_stat  = wr_en & hit(paddr, OFS_IRQ_STAT);
  wire          wr_mask  = wr_en & hit(paddr, OFS_IRQ_MASK);
  wire          mapped   = hit(paddr, OFS_CONTROL) | hit(paddr, OFS_CAPLOW)
                         | hit(paddr, OFS_CAPHIGH) | hit(paddr, OFS_CNTLOW)
                         | hit(paddr, OFS_CNTHIGH) | hit(paddr, OFS_MODE)
                         | hit(paddr, OFS_POWER) | hit(paddr, OFS_IRQ_STAT)
                         | hit(paddr, OFS_IRQ_MASK);

  // Mode decode
  wire          baud_mode = ctl_ff.rx_sel | ctl_ff.tx_sel
                          | pwr_ff[BIT_RX2] | pwr_ff[BIT_TX2];
  wire          capture_mode = ctl_ff.capsel & ~baud_mode;
  wire          down_mode = down_count_enable_ff & ~capture_mode & ~baud_mode;
  wire          count_dn  = down_mode & ~trig_lvl;
  wire          step = ctl_ff.run
                     & (ctl_ff.src ? cnt_fall : mtick);
  wire          pin_evt = ctl_ff.exen & trig_fall;
  wire          pin_act = pin_evt & ~baud_mode & ~down_mode;
  wire          do_cap  = pin_act & capture_mode;
  wire [15:0]   reload_val = {cap_hi_ff, cap_lo_ff};
  wire          up_ovf  = step & ~count_dn & (cnt_ff == 16'hFFFF);
  wire          dn_ovf  = step & count_dn & (cnt_ff == reload_val);
  wire          ovf     = up_ovf | dn_ovf;
  wire          reload_ovf = ovf & ~capture_mode;
  wire          do_rld  = pin_act & ~capture_mode;
  wire          set_ovf = ovf & ~baud_mode;
  wire          set_exf = pin_evt & (~down_mode | baud_mode);

  wire [1:0]    stat = {ctl_ff.exf, ctl_ff.ovf};
  wire [15:0]   nxt_step = count_dn ? cnt_ff - 16'h0001 : cnt_ff + 16'h0001;

  logic [15:0]  nxt_cnt_ff;
  always_comb
  begin
    nxt_cnt_ff = cnt_ff;
    if (wr_cntlo)
      nxt_cnt_ff[7:0] = pwdata[7:0];
    if (wr_cnthi)
      nxt_cnt_ff[15:8] = pwdata[7:0];
    if (do_rld)
      nxt_cnt_ff = reload_val;
    else if (dn_ovf)
      nxt_cnt_ff = 16'hFFFF;
    else if (up_ovf && reload_ovf)
      nxt_cnt_ff = reload_val;
    else if (step)
      nxt_cnt_ff = nxt_step;
  end

  // Flags: hardware set wins over software clear
  wire          clr_ovf = (wr_ctl & ~pwdata[BIT_OVF])
                        | (wr_stat & pwdata[0]);
  wire          clr_exf = (wr_ctl & ~pwdata[BIT_EXF])
                        | (wr_stat & pwdata[1]);
  wire          nxt_ovf = set_ovf | (ctl_ff.ovf & ~clr_ovf);
  wire          nxt_exf = set_exf | (ctl_ff.exf & ~clr_exf);

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ctl_ff       <= RST_CONTROL;
      cnt_ff       <= 16'h0000;
      ovf_pulse_ff <= 1'b0;
    end
    else
    begin
      if (wr_ctl)
        ctl_ff[5:0] <= pwdata[5:0];
      ctl_ff.ovf   <= nxt_ovf;
      ctl_ff.exf   <= nxt_exf;
      cnt_ff       <= nxt_cnt_ff;
      ovf_pulse_ff <= ovf;
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      cap_lo_ff <= RST_BYTE;
      cap_hi_ff <= RST_BYTE;
    end
    else if (do_cap)
    begin
      cap_lo_ff <= cnt_ff[7:0];
      cap_hi_ff <= cnt_ff[15:8];
    end
    else
    begin
      if (wr_caplo)
        cap_lo_ff <= pwdata[7:0];
      if (wr_caphi)
        cap_hi_ff <= pwdata[7:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      down_count_enable_ff  <= 1'b0;
      pwr_ff   <= 2'h0;
      imask_ff <= RST_IRQ;
    end
    else
    begin
      if (wr_mode)
        down_count_enable_ff <= pwdata[BIT_DOWN_COUNT_ENABLE];
      if (wr_pwr)
        pwr_ff <= pwdata[1:0];
      if (wr_mask)
        imask_ff <= pwdata[1:0];
    end
  end

  // Read mux
  logic [7:0]   rd_byte;
  always_comb
  begin
    rd_byte = 8'h00;
    if (hit(paddr, OFS_CONTROL))
      rd_byte = ctl_ff;
    else if (hit(paddr, OFS_CAPLOW))
      rd_byte = cap_lo_ff;
    else if (hit(paddr, OFS_CAPHIGH))
      rd_byte = cap_hi_ff;
    else if (hit(paddr, OFS_CNTLOW))
      rd_byte = cnt_ff[7:0];
    else if (hit(paddr, OFS_CNTHIGH))
      rd_byte = cnt_ff[15:8];
    else if (hit(paddr, OFS_MODE))
      rd_byte = {7'h00, down_count_enable_ff};
    else if (hit(paddr, OFS_POWER))
      rd_byte = {6'h00, pwr_ff};
    else if (hit(paddr, OFS_IRQ_STAT))
      rd_byte = {6'h00, stat};
    else if (hit(paddr, OFS_IRQ_MASK))
      rd_byte = {6'h00, imask_ff};
  end

  assign prdata  = {24'h000000, rd_byte};
  assign pready  = 1'b1;
  assign pslverr = psel & penable & ~mapped;

  assign overflow_pulse = ovf_pulse_ff;
  assign baud_sel.rx1_t2 = ctl_ff.rx_sel;
  assign baud_sel.tx1_t2 = ctl_ff.tx_sel;
  assign baud_sel.rx2_t2 = pwr_ff[BIT_RX2];
  assign baud_sel.tx2_t2 = pwr_ff[BIT_TX2];
  assign irq = |(stat & imask_ff);
endmodule
